// ### logic/gg_pkg.sv
// How it works
// [RULE1] Command 21h returns name, max seven chars
// [RULE2] Command 22h returns chemistry, max four chars
// [RULE3] Host compares chemistry codes ignoring case; gg_host only captures the answer bytes and makes no compare
// [RULE4] Command 23h returns twelve fixed manufacturer bytes
// [RULE5] Command 2Fh: status low, pack config high
// [RULE6] Status bit order fixed, bit three zero
// [RULE7] Bit seven shows front-end integrity failure
// [RULE8] Bit six set at or below threshold
// [RULE9] Bit five shows sealed state
// [RULE10] Bit four shows qualified discharge cycle
// [RULE11] Bit two latches until device reset
// [RULE12] Bit one follows overlimit, never latched
// [RULE13] Bit zero follows underlimit, never latched
// [RULE14] Commands 3Ch-3Fh return one cell each
// [RULE15] Flash read at reset, written for history
// [RULE16] Host sets address via 51h, high zero
// [RULE17] Command 52h returns addressed flash byte
// [RULE18] Command 50h writes high byte at low address
// [RULE19] Flash map: high byte first, counted strings
// [RULE20] Writing a read-only command reports access denied
// [RULE21] Held address serves repeated reads
package gg_pkg;
   // ---------------------------------------------
   // Command codes
   // ---------------------------------------------
   localparam logic [7:0] CMD_NAME = 8'h21;
   localparam logic [7:0] CMD_CHEM = 8'h22;
   localparam logic [7:0] CMD_MDATA = 8'h23;
   localparam logic [7:0] CMD_PSTAT = 8'h2F;
   localparam logic [7:0] CMD_CELL1 = 8'h3C;
   localparam logic [7:0] CMD_CELL4 = 8'h3F;
   localparam logic [7:0] CMD_FWRITE = 8'h50;
   localparam logic [7:0] CMD_FADDR = 8'h51;
   localparam logic [7:0] CMD_FREAD = 8'h52;
   // ---------------------------------------------
   // Flash map
   // ---------------------------------------------
   localparam logic [7:0] FA_MFR_NAME = 8'h0E;
   localparam logic [7:0] FA_DEV_NAME = 8'h1A;
   localparam logic [7:0] FA_CHEM = 8'h22;
   localparam logic [7:0] FA_PACK_CFG = 8'h28;
   localparam logic [7:0] NAME_MAX = 8'h07;
   localparam logic [7:0] CHEM_MAX = 8'h04;
   localparam logic [3:0] MDATA_LEN = 4'hC;
   localparam logic [3:0] CFG_LOAD_N = 4'h9;
   // ---------------------------------------------
   // Pack status bit positions
   // ---------------------------------------------
   localparam int PS_AFE = 7;
   localparam int PS_LOW_VOLTAGE_THRESHOLD_TWO = 6;
   localparam int PS_SEAL = 5;
   localparam int PS_VDQ = 4;
   localparam int PS_ZERO = 3;
   localparam int PS_SOV = 2;
   localparam int PS_OVL = 1;
   localparam int PS_UVL = 0;
   // ---------------------------------------------
   // Answer status codes
   // ---------------------------------------------
   localparam logic [1:0] ST_OK = 2'h0;
   localparam logic [1:0] ST_DENIED = 2'h1;
   localparam logic [1:0] ST_UNSUP = 2'h2;
   // ---------------------------------------------
   // Controller APB map
   // ---------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_WDATA = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_RBUF0 = 8'h10;
   localparam logic [7:0] A_RBUF3 = 8'h1C;
   localparam int CTRL_WR = 8;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_CODE = 2;
   localparam int STAT_CNT = 8;
   // ---------------------------------------------
   // State types
   // ---------------------------------------------
   typedef enum logic [1:0] {DS_LOAD = 2'b00, DS_IDLE = 2'b01, DS_RESP = 2'b11} gg_dstate_e;
   typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_REQ = 2'b01, HS_WAIT = 2'b11} gg_hstate_e;
endpackage

// ### logic/gg_link_if.sv
`timescale 1ns/1ps
interface gg_link_if;
   logic dev_ready;
   logic req_valid;
   logic req_write;
   logic [7:0] req_cmd;
   logic [15:0] req_word;
   logic rsp_valid;
   logic rsp_last;
   logic [7:0] rsp_byte;
   logic [1:0] rsp_status;
   modport dev (output dev_ready, rsp_valid, rsp_last, rsp_byte, rsp_status,
                input req_valid, req_write, req_cmd, req_word);
   modport host (input dev_ready, rsp_valid, rsp_last, rsp_byte, rsp_status,
                 output req_valid, req_write, req_cmd, req_word);
endinterface

// ### logic/gg_flash.sv
`timescale 1ns/1ps
module gg_flash #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic mclk_in,
   input wire logic we_in,
   input wire logic [AW-1:0] waddr_in,
   input wire logic [DW-1:0] wdata_in,
   input wire logic [AW-1:0] raddr_in,
   output logic [DW-1:0] rdata_out
);
   // Nonvolatile store: no reset, starts erased
   logic [DW-1:0] mem [2**AW];

   initial begin
      for (int i = 0; i < 2**AW; i++) begin
         mem[i] = '1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end

   assign rdata_out = mem[raddr_in];
endmodule

// ### logic/gg_device.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module gg_device import gg_pkg::*; #(
   parameter int CELLS = 4
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   // Command link
   gg_link_if.dev link,
   // Gauge state
   input wire logic frontend_integrity_fail_in,
   input wire logic edv_cell_mode_in,
   input wire logic [15:0] pack_mv_in,
   input wire logic [15:0] low_voltage_threshold_two_mv_in,
   input wire logic sealed_in,
   input wire logic discharge_qualified_in,
   input wire logic safety_exceeded_in,
   input wire logic secondary_overlimit_in,
   input wire logic secondary_underlimit_in,
   input wire logic [7:0] frontend_status_in,
   input wire logic [15:0] pending_edv_in,
   input wire logic [15:0] cell_voltage_words_in [CELLS],
   // History store
   input wire logic hist_store_in,
   input wire logic [7:0] hist_addr_in,
   input wire logic [7:0] hist_data_in,
   // Status
   output logic [7:0] pack_status_out,
   output logic cfg_ready_out
);
   gg_dstate_e state;
   logic [3:0] load_idx;
   logic [7:0] cfg [9];
   logic [7:0] cmd_q;
   logic [3:0] idx;
   logic [3:0] last_idx;
   logic [7:0] held_addr;
   logic sov_latch;
   logic low_voltage_threshold_two_low;
   logic hist_pend;
   logic [7:0] hist_a;
   logic [7:0] hist_d;
   logic [7:0] rd_addr;
   logic [7:0] fl_data;
   logic accept;
   logic host_we;
   logic [7:0] cur_cmd;
   logic [3:0] cur_idx;
   logic [7:0] next_byte;
   logic [3:0] next_last;
   logic [15:0] min_cell;
   logic [15:0] cell_w;

   // ---------------------------------------------
   // Decode helpers
   // ---------------------------------------------
   function automatic logic is_readable(input logic [7:0] c);
      return c == CMD_NAME || c == CMD_CHEM || c == CMD_MDATA || c == CMD_PSTAT ||
             (c >= CMD_CELL1 && c <= CMD_CELL4) || c == CMD_FREAD;
   endfunction

   function automatic logic [7:0] base_of(input logic [7:0] c, input logic [7:0] held);
      case (c)
         CMD_NAME: return FA_DEV_NAME;
         CMD_CHEM: return FA_CHEM;
         default: return held;
      endcase
   endfunction

   function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] mx);
      return (v > mx) ? mx : v;
   endfunction

   assign accept = (state == DS_IDLE) && link.dev_ready && link.req_valid;
   // [RULE18] Flash byte write
   assign host_we = accept && link.req_write && (link.req_cmd == CMD_FWRITE);
   assign cur_cmd = (state == DS_IDLE) ? link.req_cmd : cmd_q;
   assign cur_idx = (state == DS_IDLE) ? 4'h0 : idx;

   // ---------------------------------------------
   // Flash access
   // ---------------------------------------------
   always_comb begin
      if (state == DS_LOAD) begin
         rd_addr = FA_PACK_CFG + {4'h0, load_idx};
      end else begin
         rd_addr = base_of(cur_cmd, held_addr) + {4'h0, cur_idx};
      end
   end

   // [RULE15] History write port
   gg_flash #(.AW(8), .DW(8)) u_flash (
      .mclk_in(mclk_in),
      .we_in(host_we || hist_pend),
      .waddr_in(host_we ? link.req_word[7:0] : hist_a),
      .wdata_in(host_we ? link.req_word[15:8] : hist_d),
      .raddr_in(rd_addr),
      .rdata_out(fl_data)
   );

   // History write yields to host write
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hist_pend <= 1'b0;
         hist_a <= 8'h00;
         hist_d <= 8'h00;
      end else if (hist_store_in) begin
         hist_pend <= 1'b1;
         hist_a <= hist_addr_in;
         hist_d <= hist_data_in;
      end else if (!host_we) begin
         hist_pend <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Pack status
   // ---------------------------------------------
   always_comb begin
      min_cell = cell_voltage_words_in[0];
      for (int i = 1; i < CELLS; i++) begin
         if (cell_voltage_words_in[i] < min_cell) begin
            min_cell = cell_voltage_words_in[i];
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sov_latch <= 1'b0;
         low_voltage_threshold_two_low <= 1'b0;
      end else begin
         // [RULE11] Sticky until reset
         sov_latch <= sov_latch | safety_exceeded_in;
         // [RULE8] At or below threshold
         low_voltage_threshold_two_low <= (edv_cell_mode_in ? min_cell : pack_mv_in) <= low_voltage_threshold_two_mv_in;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pack_status_out <= 8'h00;
      end else begin
         // [RULE6] Bit assembly
         pack_status_out[PS_ZERO] <= 1'b0;
         // [RULE7] Integrity failure
         pack_status_out[PS_AFE] <= frontend_integrity_fail_in;
         pack_status_out[PS_LOW_VOLTAGE_THRESHOLD_TWO] <= low_voltage_threshold_two_low;
         // [RULE9] Seal state
         pack_status_out[PS_SEAL] <= sealed_in;
         // [RULE10] Qualified discharge
         pack_status_out[PS_VDQ] <= discharge_qualified_in;
         pack_status_out[PS_SOV] <= sov_latch;
         // [RULE12] Unlatched overlimit
         pack_status_out[PS_OVL] <= secondary_overlimit_in;
         // [RULE13] Unlatched underlimit
         pack_status_out[PS_UVL] <= secondary_underlimit_in;
      end
   end

   // ---------------------------------------------
   // Answer byte selection
   // ---------------------------------------------
   always_comb begin
      next_byte = 8'h00;
      next_last = 4'h0;
      cell_w = cell_voltage_words_in[cur_cmd[1:0]];
      case (cur_cmd)
         // [RULE1] Device name string
         CMD_NAME: begin
            next_byte = (cur_idx == 4'h0) ? clamp(fl_data, NAME_MAX) : fl_data;
            next_last = 4'(clamp(fl_data, NAME_MAX));
         end
         // [RULE2] Chemistry string, max four chars
         CMD_CHEM: begin
            next_byte = (cur_idx == 4'h0) ? clamp(fl_data, CHEM_MAX) : fl_data;
            next_last = 4'(clamp(fl_data, CHEM_MAX));
         end
         // [RULE4] Manufacturer block
         CMD_MDATA: begin
            next_last = MDATA_LEN;
            if (cur_idx == 4'h0) begin
               next_byte = {4'h0, MDATA_LEN};
            end else if (cur_idx <= CFG_LOAD_N) begin
               next_byte = cfg[cur_idx - 4'h1];
            end else if (cur_idx == 4'hA) begin
               next_byte = frontend_status_in;
            end else if (cur_idx == 4'hB) begin
               next_byte = pending_edv_in[7:0];
            end else begin
               next_byte = pending_edv_in[15:8];
            end
         end
         // [RULE5] Status low, config high
         CMD_PSTAT: begin
            next_last = 4'h1;
            next_byte = (cur_idx == 4'h0) ? pack_status_out : cfg[0];
         end
         // [RULE17] Addressed flash byte
         CMD_FREAD: begin
            next_last = 4'h1;
            next_byte = (cur_idx == 4'h0) ? fl_data : 8'h00;
         end
         default: begin
            // [RULE14] One cell per command
            if (cur_cmd >= CMD_CELL1 && cur_cmd <= CMD_CELL4) begin
               next_last = 4'h1;
               next_byte = (cur_idx == 4'h0) ? cell_w[7:0] : cell_w[15:8];
            end
         end
      endcase
   end

   // ---------------------------------------------
   // Sequencer
   // ---------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= DS_LOAD;
         load_idx <= 4'h0;
         cmd_q <= 8'h00;
         idx <= 4'h0;
         last_idx <= 4'h0;
         held_addr <= 8'h00;
         cfg_ready_out <= 1'b0;
         link.dev_ready <= 1'b0;
         link.rsp_valid <= 1'b0;
         link.rsp_last <= 1'b0;
         link.rsp_byte <= 8'h00;
         link.rsp_status <= ST_OK;
      end else begin
         link.rsp_valid <= 1'b0;
         link.rsp_last <= 1'b0;
         link.dev_ready <= 1'b0;
         case (state)
            // [RULE15] Configuration copy after reset
            DS_LOAD: begin
               load_idx <= load_idx + 4'h1;
               if (load_idx == CFG_LOAD_N - 4'h1) begin
                  state <= DS_IDLE;
                  cfg_ready_out <= 1'b1;
                  link.dev_ready <= 1'b1;
               end
            end
            DS_IDLE: begin
               link.dev_ready <= !accept;
               if (accept) begin
                  link.rsp_valid <= 1'b1;
                  link.rsp_byte <= 8'h00;
                  link.rsp_status <= ST_OK;
                  if (link.req_write) begin
                     link.rsp_last <= 1'b1;
                     if (link.req_cmd == CMD_FADDR) begin
                        // [RULE21] Held address
                        held_addr <= link.req_word[7:0];
                     end else if (link.req_cmd != CMD_FWRITE) begin
                        // [RULE20] Read-only write refused
                        link.rsp_status <= is_readable(link.req_cmd) ? ST_DENIED : ST_UNSUP;
                     end
                  end else if (is_readable(link.req_cmd)) begin
                     link.rsp_byte <= next_byte;
                     cmd_q <= link.req_cmd;
                     idx <= 4'h1;
                     last_idx <= next_last;
                     link.rsp_last <= (next_last == 4'h0);
                     link.dev_ready <= 1'b0;
                     if (next_last != 4'h0) begin
                        state <= DS_RESP;
                     end
                  end else begin
                     link.rsp_last <= 1'b1;
                     link.rsp_status <= ST_UNSUP;
                  end
               end
            end
            DS_RESP: begin
               link.rsp_valid <= 1'b1;
               link.rsp_byte <= next_byte;
               idx <= idx + 4'h1;
               if (idx == last_idx) begin
                  link.rsp_last <= 1'b1;
                  state <= DS_IDLE;
               end
            end
            default: begin
               state <= DS_IDLE;
            end
         endcase
      end
   end

   // Config shadow, taken at load
   always_ff @(posedge mclk_in) begin
      if (state == DS_LOAD) begin
         cfg[load_idx] <= fl_data;
      end
   end
endmodule

// ### logic/gg_host.sv
`timescale 1ns/1ps
module gg_host import gg_pkg::*; (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Command link
   gg_link_if.host link
);
   gg_hstate_e state;
   logic [7:0] cmd_r;
   logic wr_r;
   logic [15:0] word_r;
   logic busy;
   logic done;
   logic [1:0] code;
   logic [3:0] count;
   logic [7:0] rbuf [16];
   logic wr_acc;
   logic setup;
   logic [1:0] rsel;

   assign setup = psel_in && !penable_in;
   assign wr_acc = psel_in && penable_in && pready_out && pwrite_in;
   assign rsel = paddr_in[3:2];

   // ---------------------------------------------
   // APB answer, zero wait states
   // ---------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h00000000;
      end else begin
         pready_out <= setup;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h00000000;
         if (setup) begin
            case (paddr_in)
               A_CTRL: prdata_out <= {23'h000000, wr_r, cmd_r};
               A_WDATA: prdata_out <= {16'h0000, word_r};
               A_STAT: prdata_out <= {20'h00000, count, 4'h0, code, done, busy};
               default: begin
                  if (paddr_in >= A_RBUF0 && paddr_in <= A_RBUF3 && paddr_in[1:0] == 2'b00) begin
                     prdata_out <= {rbuf[{rsel, 2'h3}], rbuf[{rsel, 2'h2}], rbuf[{rsel, 2'h1}], rbuf[{rsel, 2'h0}]};
                  end else begin
                     pslverr_out <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // ---------------------------------------------
   // Command sequencing
   // ---------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= HS_IDLE;
         cmd_r <= 8'h00;
         wr_r <= 1'b0;
         word_r <= 16'h0000;
         busy <= 1'b0;
         done <= 1'b0;
         code <= ST_OK;
         count <= 4'h0;
         link.req_valid <= 1'b0;
         link.req_write <= 1'b0;
         link.req_cmd <= 8'h00;
         link.req_word <= 16'h0000;
      end else begin
         link.req_valid <= 1'b0;
         if (wr_acc && paddr_in == A_WDATA && !busy) begin
            word_r <= pwdata_in[15:0];
         end
         case (state)
            HS_IDLE: begin
               // Starts ignored while busy
               if (wr_acc && paddr_in == A_CTRL) begin
                  cmd_r <= pwdata_in[7:0];
                  wr_r <= pwdata_in[CTRL_WR];
                  busy <= 1'b1;
                  done <= 1'b0;
                  count <= 4'h0;
                  state <= HS_REQ;
               end
            end
            HS_REQ: begin
               if (link.dev_ready) begin
                  link.req_valid <= 1'b1;
                  link.req_write <= wr_r;
                  link.req_cmd <= cmd_r;
                  // [RULE16] Address set carries zero high byte
                  link.req_word <= (cmd_r == CMD_FADDR) ? {8'h00, word_r[7:0]} : word_r;
                  state <= HS_WAIT;
               end
            end
            HS_WAIT: begin
               if (link.rsp_valid) begin
                  count <= count + 4'h1;
                  if (link.rsp_last) begin
                     busy <= 1'b0;
                     done <= 1'b1;
                     code <= link.rsp_status;
                     state <= HS_IDLE;
                  end
               end
            end
            default: begin
               state <= HS_IDLE;
            end
         endcase
      end
   end

   // [RULE17] Captured answer bytes
   always_ff @(posedge mclk_in) begin
      if (state == HS_WAIT && link.rsp_valid) begin
         rbuf[count] <= link.rsp_byte;
      end
   end
endmodule

// ### dv/gg_link_asserts.sv
`timescale 1ns/1ps
module gg_link_asserts import gg_pkg::*; (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_b_in,
   // Link
   input wire logic dev_ready,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [7:0] req_cmd,
   input wire logic [15:0] req_word,
   input wire logic rsp_valid,
   input wire logic rsp_last,
   input wire logic [7:0] rsp_byte,
   input wire logic [1:0] rsp_status
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   wire acc = dev_ready && req_valid;
   sequence s_rd(c);
      acc && !req_write && req_cmd == c;
   endsequence
   sequence s_word;
      rsp_valid && !rsp_last ##1 rsp_valid && rsp_last;
   endsequence
   property p_first; acc |=> rsp_valid; endproperty
   a_first: assert property (p_first) else $error("no answer");
   property p_gap; rsp_valid && !rsp_last |=> rsp_valid; endproperty
   a_gap: assert property (p_gap) else $error("answer gap");
   property p_busy; rsp_valid |-> !dev_ready; endproperty
   a_busy: assert property (p_busy) else $error("early ready");
   property p_name; s_rd(CMD_NAME) |=> rsp_byte <= NAME_MAX; endproperty
   a_name: assert property (p_name) else $error("name len");
   property p_chem; s_rd(CMD_CHEM) |=> rsp_byte <= CHEM_MAX; endproperty
   a_chem: assert property (p_chem) else $error("chem len");
   property p_mdata; s_rd(CMD_MDATA) |=> rsp_byte == 8'h0C && !rsp_last ##12 rsp_last; endproperty
   a_mdata: assert property (p_mdata) else $error("block len");
   property p_pstat; s_rd(CMD_PSTAT) |=> s_word; endproperty
   a_pstat: assert property (p_pstat) else $error("status len");
   property p_cell; acc && !req_write && req_cmd >= CMD_CELL1 && req_cmd <= CMD_CELL4 |=> s_word; endproperty
   a_cell: assert property (p_cell) else $error("cell len");
   property p_fread; s_rd(CMD_FREAD) |=> rsp_valid ##1 rsp_last && rsp_byte == 8'h00; endproperty
   a_fread: assert property (p_fread) else $error("fread high");
   property p_fwr;
      acc && req_write && (req_cmd == CMD_FWRITE || req_cmd == CMD_FADDR)
         |=> rsp_last && rsp_byte == 8'h00 && rsp_status == ST_OK;
   endproperty
   a_fwr: assert property (p_fwr) else $error("write answer");
   property p_deny; acc && req_write && req_cmd == CMD_PSTAT |=> rsp_last && rsp_status == ST_DENIED; endproperty
   a_deny: assert property (p_deny) else $error("not denied");
endmodule

// ### dv/gauge_smbus_ident_status_flash_access_bench.sv
`timescale 1ns/1ps
module gauge_smbus_ident_status_flash_access_bench import gg_pkg::*; ();
   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   logic mclk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, perr, prdy, err, cr;
   logic afe = 1'b0, cm = 1'b0, sl = 1'b0, dq = 1'b0, sx = 1'b0, ovl = 1'b0, uvl = 1'b0, hs = 1'b0;
   logic [7:0] pa = 8'h00, fes = 8'h3C, ha = 8'h00, hd = 8'h00, ps;
   logic [31:0] pwd = 32'h0, prd, rd, st;
   logic [15:0] pmv = 16'h0, edv = 16'h0D40, pend = 16'h1234;
   logic [15:0] cv [4];
   logic [7:0] rb [16];
   int n_fail = 0;
   int n_compared = 0;
   gg_link_if gg_link_if_inst ();
   gg_device gg_device_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .link(gg_link_if_inst),
      .frontend_integrity_fail_in(afe), .edv_cell_mode_in(cm), .pack_mv_in(pmv), .low_voltage_threshold_two_mv_in(edv),
      .sealed_in(sl), .discharge_qualified_in(dq), .safety_exceeded_in(sx), .secondary_overlimit_in(ovl),
      .secondary_underlimit_in(uvl), .frontend_status_in(fes), .pending_edv_in(pend),
      .cell_voltage_words_in(cv), .hist_store_in(hs), .hist_addr_in(ha), .hist_data_in(hd),
      .pack_status_out(ps), .cfg_ready_out(cr));
   gg_host gg_host_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
      .pslverr_out(perr), .link(gg_link_if_inst));
   gg_link_asserts gg_link_asserts_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
      .dev_ready(gg_link_if_inst.dev_ready), .req_valid(gg_link_if_inst.req_valid),
      .req_write(gg_link_if_inst.req_write), .req_cmd(gg_link_if_inst.req_cmd),
      .req_word(gg_link_if_inst.req_word), .rsp_valid(gg_link_if_inst.rsp_valid),
      .rsp_last(gg_link_if_inst.rsp_last), .rsp_byte(gg_link_if_inst.rsp_byte),
      .rsp_status(gg_link_if_inst.rsp_status));
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task summarize;
      if (n_fail == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge mclk_in) pen <= 1'b1;
      do @(posedge mclk_in); while (prdy !== 1'b1);
      rd = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // Run one command, fetch answer
   task cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
      apb(1'b1, A_WDATA, {16'h0, d});
      apb(1'b1, A_CTRL, {23'h0, w, c});
      do apb(1'b0, A_STAT, 32'h0); while (rd[STAT_DONE] !== 1'b1);
      st = rd;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, A_RBUF0 + 8'(4 * i), 32'h0);
         for (int j = 0; j < 4; j++) rb[4 * i + j] = rd[8 * j +: 8];
      end
   endtask
   task res(input logic [1:0] c, input logic [3:0] n);
      chk(32'(st[3:2]), 32'(c));
      chk(32'(st[11:8]), 32'(n));
   endtask
   task fw(input logic [7:0] a, input logic [7:0] d);
      cmd(1'b1, CMD_FWRITE, {d, a});
   endtask
   task fr(input logic [7:0] a);
      cmd(1'b1, CMD_FADDR, {8'h00, a});
      cmd(1'b0, CMD_FREAD, 16'h0);
   endtask
   task rst;
      @(posedge mclk_in) rst_b_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      do @(posedge mclk_in); while (cr !== 1'b1);
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task t_flash;
      fw(8'h40, 8'hA5);
      res(ST_OK, 4'h1);
      fw(8'h41, 8'h5A);
      cmd(1'b1, CMD_FADDR, 16'h0041);
      res(ST_OK, 4'h1);
      cmd(1'b0, CMD_FREAD, 16'h0);
      chk({16'h0, rb[1], rb[0]}, 32'h5A);
      cmd(1'b0, CMD_FREAD, 16'h0);
      chk({16'h0, rb[1], rb[0]}, 32'h5A);
      fr(8'h40);
      chk({16'h0, rb[1], rb[0]}, 32'hA5);
   endtask
   task t_str;
      // Length above limit is clamped
      fw(FA_DEV_NAME, 8'h09);
      for (int i = 1; i < 8; i++) fw(FA_DEV_NAME + 8'(i), 8'h40 + 8'(i));
      fw(FA_CHEM, 8'h04);
      for (int i = 1; i < 5; i++) fw(FA_CHEM + 8'(i), 8'h60 + 8'(i));
      cmd(1'b0, CMD_NAME, 16'h0);
      res(ST_OK, 4'h8);
      chk({24'h0, rb[0]}, 32'h07);
      for (int i = 1; i < 8; i++) chk({24'h0, rb[i]}, 32'h40 + i);
      cmd(1'b0, CMD_CHEM, 16'h0);
      res(ST_OK, 4'h5);
      for (int i = 0; i < 5; i++) chk({24'h0, rb[i]}, (i == 0) ? 32'h04 : 32'h60 + i);
   endtask
   task t_cfg;
      for (int i = 0; i < 9; i++) fw(FA_PACK_CFG + 8'(i), 8'h10 + 8'(i));
      // Shadow loads only at reset
      rst;
      chk({31'h0, cr}, 32'h1);
      cmd(1'b0, CMD_MDATA, 16'h0);
      res(ST_OK, 4'hD);
      chk({24'h0, rb[0]}, 32'h0C);
      for (int i = 0; i < 9; i++) chk({24'h0, rb[1 + i]}, 32'h10 + i);
      chk({8'h0, rb[12], rb[11], rb[10]}, {8'h0, pend, fes});
   endtask
   task t_stat;
      @(posedge mclk_in);
      {afe, sl, dq, ovl, uvl, sx} <= 6'b110101;
      pmv <= edv;
      @(posedge mclk_in) sx <= 1'b0;
      repeat (3) @(posedge mclk_in);
      chk({24'h0, ps}, 32'hE6);
      cmd(1'b0, CMD_PSTAT, 16'h0);
      chk({16'h0, rb[1], rb[0]}, 32'h10E6);
      @(posedge mclk_in);
      {afe, sl, dq, ovl, uvl} <= 5'b00101;
      pmv <= edv + 16'h1;
      repeat (3) @(posedge mclk_in);
      chk({24'h0, ps}, 32'h15);
      cm <= 1'b1;
      repeat (3) @(posedge mclk_in);
      chk({24'h0, ps}, 32'h55);
      rst;
      repeat (3) @(posedge mclk_in);
      chk({24'h0, ps}, 32'h51);
   endtask
   task t_cell;
      for (int i = 0; i < 4; i++) begin
         cmd(1'b0, CMD_CELL1 + 8'(i), 16'h0);
         chk({16'h0, rb[1], rb[0]}, {16'h0, cv[i]});
      end
   endtask
   task t_err;
      cmd(1'b1, CMD_PSTAT, 16'h0);
      res(ST_DENIED, 4'h1);
      cmd(1'b0, CMD_FWRITE, 16'h0);
      res(ST_UNSUP, 4'h1);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
   endtask
   task t_hist;
      @(posedge mclk_in);
      hs <= 1'b1; ha <= 8'h60; hd <= 8'hC3;
      @(posedge mclk_in) hs <= 1'b0;
      fr(8'h60);
      chk({24'h0, rb[0]}, 32'hC3);
   endtask
   // ---------------------------------------------
   // Run
   // ---------------------------------------------
   initial forever #4 mclk_in = ~mclk_in;
   initial begin
      #200000;
      n_fail++;
      summarize;
   end
   initial begin
      for (int i = 0; i < 4; i++) cv[i] = 16'h0D40 + 16'(i);
      repeat (8) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      t_flash;
      t_str;
      t_cfg;
      t_stat;
      t_cell;
      t_err;
      t_hist;
      summarize;
   end
endmodule
